/* File: hdl/slpc_cfg.svh */
// sleep controller constants: offsets, fields, reset values, timing
`ifndef SLPC_CFG_SVH
`define SLPC_CFG_SVH
// ------------------------------------------------------------
// register offsets (byte addresses on the bus)
// ------------------------------------------------------------
`define SLPC_OFF_CTRL      8'h00
`define SLPC_OFF_WAKE      8'h04
`define SLPC_OFF_STAT      8'h08
// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define SLPC_CTRL_ACOFF    3
`define SLPC_CTRL_ADCEN    4
`define SLPC_STAT_RSV      4
`define SLPC_CTRL_RST      8'h00
`define SLPC_WAKE_RST      8'h00
`define SLPC_FUSE_XTAL_BIT 3
// ------------------------------------------------------------
// sleep-mode select codes
// ------------------------------------------------------------
`define SLPC_SM_IDLE       3'h0
`define SLPC_SM_ADCNR      3'h1
`define SLPC_SM_PDOWN      3'h2
`define SLPC_SM_STBY       3'h6
// ------------------------------------------------------------
// timing: clock rate, restart times, standby wake
// ------------------------------------------------------------
`define SLPC_PCLK_MHZ      25
`define SLPC_START_XTAL_US 16000
`define SLPC_START_RC_US   64
`define SLPC_START_RC_CYC  (`SLPC_START_RC_US * `SLPC_PCLK_MHZ)
`define SLPC_START_XT_CYC  (`SLPC_START_XTAL_US * `SLPC_PCLK_MHZ)
`define SLPC_STBY_WAKE_CYC 6
`endif

/* File: hdl/slpc_pkg.sv */
// sleep controller types
package slpc_pkg;
   typedef enum logic [1:0] {SLPC_M_IDLE, SLPC_M_ADCNR, SLPC_M_PDOWN, SLPC_M_STBY} slpc_mode_t;
   typedef enum logic [1:0] {SLPC_ST_RUN, SLPC_ST_SLEEP, SLPC_ST_START} slpc_state_t;
endpackage : slpc_pkg

/* File: hdl/slpc_wake_if.sv */
// links the sleep controller to its wake qualifier and restart timer
`timescale 1ns/10ps
`default_nettype none
interface slpc_wake_if;
   import slpc_pkg::*;
   slpc_mode_t  mode;
   logic        armed;
   logic        wake;
   logic        ld;
   logic [23:0] cnt;
   logic        done;
   modport ctl  (output mode, armed, ld, cnt, input wake, done);
   modport qual (input mode, armed, output wake);
   modport tmr  (input ld, cnt, output done);
endinterface : slpc_wake_if
`default_nettype wire

/* File: hdl/slpc_wake_qual.sv */
// wake qualifier: pin synchronisers and per-mode wake source masks
`timescale 1ns/10ps
`default_nettype none
module slpc_wake_qual
   import slpc_pkg::*;
(
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // asynchronous pins
   input  wire logic [3:0] external_irq_pins,
   input  wire logic       rst_external_n,
   input  wire logic       rst_watchdog,
   input  wire logic       rst_brownout,
   // same-domain sources and enables
   input  wire logic [8:0] irq_src,
   input  wire logic [3:0] ext_en,
   input  wire logic [3:0] ext_lvl,
   input  wire logic       acoff,
   // controller side
   slpc_wake_if.qual       wif
);
   logic [6:0] pin_a;
   logic [6:0] s1_q;
   logic [6:0] s2_q;
   logic       wake_q;
   logic       lvl_hit;
   logic       rst_hit;
   logic       idle_hit;
   logic       adcnr_hit;
   logic       pd_hit;
   logic       hit;
   assign pin_a = {~rst_external_n, rst_watchdog, rst_brownout, external_irq_pins};
   // two flops per pin; only the second one is looked at
   for (genvar i = 0; i < 7; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            // idle levels: pins high, reset requests low
            s1_q[i] <= 1'(i < 4);
            s2_q[i] <= 1'(i < 4);
         end else begin
            s1_q[i] <= pin_a[i];
            s2_q[i] <= s1_q[i];
         end
      end
   end
   // low level needs no io clock, so it wakes from every mode
   assign lvl_hit   = |(~s2_q[3:0] & ext_en & ext_lvl);
   assign rst_hit   = s2_q[6] | s2_q[5] | s2_q[4];
   // src: 0 timer 1 uart 2 spi 3 comparator 4 adc 5 spm 6 psc 7 io 8 edge
   assign idle_hit  = lvl_hit | rst_hit | (|irq_src[2:0]) | (irq_src[3] & ~acoff)
                    | (|irq_src[8:4]);
   assign adcnr_hit = lvl_hit | rst_hit | irq_src[4] | irq_src[0] | irq_src[5];
   assign pd_hit    = lvl_hit | rst_hit | irq_src[6];
   // standby shares the power-down source set
   assign hit = (wif.mode == SLPC_M_IDLE)  ? idle_hit :
                (wif.mode == SLPC_M_ADCNR) ? adcnr_hit : pd_hit;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) wake_q <= 1'b0;
      else          wake_q <= wif.armed & hit;
   end
   assign wif.wake = wake_q;
endmodule : slpc_wake_qual
`default_nettype wire

/* File: hdl/slpc_wake_timer.sv */
// restart timer: one done pulse a loaded number of cycles after load
`timescale 1ns/10ps
`default_nettype none
module slpc_wake_timer (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // controller side
   slpc_wake_if.tmr  wif
);
   logic [23:0] cnt_q;
   logic        done_q;
   // counts down; the load value is the distance to done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q  <= 24'h0;
         done_q <= 1'b0;
      end else if (wif.ld) begin
         cnt_q  <= wif.cnt;
         done_q <= 1'b0;
      end else begin
         done_q <= (cnt_q == 24'h1);
         cnt_q  <= (cnt_q == 24'h0) ? 24'h0 : cnt_q - 24'h1;
      end
   end
   assign wif.done = done_q;
endmodule : slpc_wake_timer
`default_nettype wire

/* File: hdl/slpc_sleep_ctrl.sv */
// sleep controller top: register slave, mode sequencer, clock gating
`timescale 1ns/10ps
`default_nettype none
`include "slpc_cfg.svh"
module slpc_sleep_ctrl
   import slpc_pkg::*;
#(
   parameter int unsigned START_XT_CYC = `SLPC_START_XT_CYC
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // cpu side
   input  wire logic        sleep_instr,
   output logic             cpu_resume,
   output logic             sleeping,
   // fuse pins
   input  wire logic [3:0]  clock_source_select_fuses,
   // asynchronous wake pins
   input  wire logic [3:0]  external_irq_pins,
   input  wire logic        rst_external_n,
   input  wire logic        rst_watchdog,
   input  wire logic        rst_brownout,
   // peripheral interrupt requests
   input  wire logic        irq_timer,
   input  wire logic        irq_uart_txc,
   input  wire logic        irq_spi,
   input  wire logic        irq_comparator,
   input  wire logic        irq_adc_done,
   input  wire logic        irq_spm_ee_ready,
   input  wire logic        irq_power_stage_controller,
   input  wire logic        irq_other_io,
   input  wire logic        irq_ext_edge,
   // clock domain enables
   output logic             clk_cpu_en,
   output logic             clk_flash_en,
   output logic             clk_io_en,
   output logic             clk_adc_en,
   output logic             clk_pll_en,
   output logic             osc_en,
   // analog controls
   output logic             comparator_pd,
   output logic             adc_start
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   slpc_wake_if wif ();
   slpc_state_t state_q;
   slpc_state_t state_d;
   slpc_mode_t  mode_q;
   slpc_mode_t  mode_d;
   logic [7:0]  ctrl_q;
   logic [7:0]  wake_q;
   logic        rsv_q;
   logic [31:0] rdata_q;
   logic [3:0]  fuse_s1_q;
   logic [3:0]  fuse_s2_q;
   logic [5:0]  gate_q;
   logic [5:0]  gate_d;
   logic        start_q;
   logic        resume_q;
   logic        ld_q;
   logic [23:0] ld_cnt_q;
   logic        setup;
   logic        wr;
   logic        sel_ctrl;
   logic        sel_wake;
   logic        sel_stat;
   logic        mapped;
   logic [31:0] rd_mux;
   logic [2:0]  sm;
   logic        xtal;
   logic        go;
   logic        go_ok;
   logic        go_rsv;
   logic        rsv_clr;
   logic        wake_ev;
   logic        slow_mode;
   logic [23:0] start_cnt;
   slpc_mode_t  dec_mode;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // zero wait states: every access completes in its first access cycle
   // an address that maps no register answers with pslverr
   assign pready   = 1'b1;
   assign setup    = psel & ~penable;
   assign wr       = psel & penable & pwrite;
   assign sel_ctrl = (paddr == `SLPC_OFF_CTRL);
   assign sel_wake = (paddr == `SLPC_OFF_WAKE);
   assign sel_stat = (paddr == `SLPC_OFF_STAT);
   assign mapped   = sel_ctrl | sel_wake | sel_stat;
   assign pslverr  = psel & penable & ~mapped;
   assign rsv_clr  = wr & sel_stat & pwdata[`SLPC_STAT_RSV];

   // read mux; unmapped addresses read as zero
   assign rd_mux = sel_ctrl ? {24'h0, ctrl_q} :
                   sel_wake ? {24'h0, wake_q} :
                   sel_stat ? {26'h0, xtal, rsv_q, mode_q,
                               state_q == SLPC_ST_START, state_q != SLPC_ST_RUN} :
                   32'h0;

   // read data captured in the setup cycle, valid through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)   rdata_q <= 32'h0;
      else if (setup) rdata_q <= rd_mux;
   end
   assign prdata = rdata_q;

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   // control: mode select, comparator power-off, adc enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)             ctrl_q <= `SLPC_CTRL_RST;
      else if (wr && sel_ctrl)  ctrl_q <= {3'h0, pwdata[4:0]};
   end

   // wake: external pin enables low nibble, level mode high nibble
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)             wake_q <= `SLPC_WAKE_RST;
      else if (wr && sel_wake)  wake_q <= pwdata[7:0];
   end

   // reserved-code flag: a new refusal wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)     rsv_q <= 1'b0;
      else if (go_rsv)  rsv_q <= 1'b1;
      else if (rsv_clr) rsv_q <= 1'b0;
   end

   // field views of the control register
   assign sm            = ctrl_q[2:0];
   assign comparator_pd = ctrl_q[`SLPC_CTRL_ACOFF];

   // ------------------------------------------------------------
   // fuse pins
   // ------------------------------------------------------------
   // fuses are static but still pass two flops before use
   // bit 3 set means a crystal drives the main clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_s1_q <= 4'h0;
         fuse_s2_q <= 4'h0;
      end else begin
         fuse_s1_q <= clock_source_select_fuses;
         fuse_s2_q <= fuse_s1_q;
      end
   end
   assign xtal = fuse_s2_q[`SLPC_FUSE_XTAL_BIT];

   // restart delay follows the same fuses as the reset time-out
   assign start_cnt = xtal ? START_XT_CYC[23:0] :
                             24'(`SLPC_START_RC_CYC);

   // ------------------------------------------------------------
   // sleep command decode
   // ------------------------------------------------------------
   // standby is only honoured with a crystal; the fuse pins own that choice
   assign dec_mode = (sm == `SLPC_SM_IDLE)  ? SLPC_M_IDLE :
                     (sm == `SLPC_SM_ADCNR) ? SLPC_M_ADCNR :
                     (sm == `SLPC_SM_PDOWN) ? SLPC_M_PDOWN : SLPC_M_STBY;
   assign go_ok    = (sm == `SLPC_SM_IDLE) | (sm == `SLPC_SM_ADCNR) |
                     (sm == `SLPC_SM_PDOWN) | ((sm == `SLPC_SM_STBY) & xtal);
   // a sleep request is heard only while running
   assign go       = sleep_instr & (state_q == SLPC_ST_RUN);
   assign go_rsv   = go & ~go_ok;
   assign wake_ev  = wif.wake & (state_q == SLPC_ST_SLEEP);
   assign slow_mode = (mode_q == SLPC_M_PDOWN) | (mode_q == SLPC_M_STBY);

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   // next state and mode
   always_comb begin
      state_d = state_q;
      mode_d  = mode_q;
      case (state_q)
         SLPC_ST_RUN: begin
            if (go && go_ok) begin
               state_d = SLPC_ST_SLEEP;
               mode_d  = dec_mode;
            end
         end
         SLPC_ST_SLEEP: begin
            // idle and adc noise resume at once, the others must restart
            if (wake_ev) begin
               state_d = slow_mode ? SLPC_ST_START : SLPC_ST_RUN;
            end
         end
         SLPC_ST_START: begin
            if (wif.done) state_d = SLPC_ST_RUN;
         end
         default: state_d = SLPC_ST_RUN;
      endcase
   end

   // state register
   // the mode is kept while asleep so the wake mask stays valid
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= SLPC_ST_RUN;
         mode_q  <= SLPC_M_IDLE;
      end else begin
         state_q <= state_d;
         mode_q  <= mode_d;
      end
   end

   // restart timer load on wake from power-down or standby
   // the load flop and the state register add a cycle each, so the count
   // is trimmed by two; restart counts below three are not supported
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ld_q     <= 1'b0;
         ld_cnt_q <= 24'h0;
      end else begin
         ld_q     <= 1'b0;
         if (wake_ev && slow_mode) begin
            ld_q     <= 1'b1;
            ld_cnt_q <= (mode_q == SLPC_M_STBY) ?
                        24'(`SLPC_STBY_WAKE_CYC - 2) :
                        start_cnt - 24'h2;
         end
      end
   end

   // one-cycle pulses: conversion start on entry, resume on exit
   // resume fires with the enables, as the state returns to run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_q  <= 1'b0;
         resume_q <= 1'b0;
      end else begin
         start_q  <= go & go_ok & ctrl_q[`SLPC_CTRL_ADCEN] &
                     ((sm == `SLPC_SM_IDLE) | (sm == `SLPC_SM_ADCNR));
         resume_q <= (state_q != SLPC_ST_RUN) & (state_d == SLPC_ST_RUN);
      end
   end
   assign adc_start  = start_q;
   assign cpu_resume = resume_q;

   // ------------------------------------------------------------
   // clock gating
   // ------------------------------------------------------------
   // order: cpu, flash, io, adc, pll, oscillator
   // the oscillator runs again during the restart wait so it can settle
   // standby keeps the oscillator, so its wait is short
   always_comb begin
      gate_d = 6'h3f;
      if (state_d == SLPC_ST_START) begin
         gate_d = 6'h20;
      end else if (state_d == SLPC_ST_SLEEP) begin
         case (mode_d)
            SLPC_M_IDLE:  gate_d = 6'h3c;
            SLPC_M_ADCNR: gate_d = 6'h38;
            SLPC_M_PDOWN: gate_d = 6'h00;
            SLPC_M_STBY:  gate_d = 6'h20;
            default:      gate_d = 6'h3f;
         endcase
      end
   end

   // enables come from flops so no glitch reaches a clock gate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) gate_q <= 6'h3f;
      else          gate_q <= gate_d;
   end
   assign clk_cpu_en   = gate_q[0];
   assign clk_flash_en = gate_q[1];
   assign clk_io_en    = gate_q[2];
   assign clk_adc_en   = gate_q[3];
   assign clk_pll_en   = gate_q[4];
   assign osc_en       = gate_q[5];
   assign sleeping     = ~gate_q[0];

   // ------------------------------------------------------------
   // wake qualifier and restart timer
   // ------------------------------------------------------------
   // the qualifier listens only while asleep
   assign wif.mode  = mode_q;
   assign wif.armed = (state_q == SLPC_ST_SLEEP);
   assign wif.ld    = ld_q;
   assign wif.cnt   = ld_cnt_q;

   // level sources must outlast the restart to raise their interrupt
   slpc_wake_qual u_qual (
      .pclk              (pclk),
      .presetn           (presetn),
      .external_irq_pins (external_irq_pins),
      .rst_external_n    (rst_external_n),
      .rst_watchdog      (rst_watchdog),
      .rst_brownout      (rst_brownout),
      .irq_src           ({irq_ext_edge, irq_other_io, irq_power_stage_controller,
                           irq_spm_ee_ready, irq_adc_done, irq_comparator,
                           irq_spi, irq_uart_txc, irq_timer}),
      .ext_en            (wake_q[3:0]),
      .ext_lvl           (wake_q[7:4]),
      .acoff             (ctrl_q[`SLPC_CTRL_ACOFF]),
      .wif               (wif.qual)
   );

   // one timer serves the crystal, rc and standby waits
   slpc_wake_timer u_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .wif     (wif.tmr)
   );
endmodule : slpc_sleep_ctrl
`default_nettype wire

/* File: verif/slpc_sleep_ctrl_props.sv */
// assertion checker bound to the sleep controller top
`timescale 1ns/10ps
`default_nettype none
module slpc_sleep_ctrl_props (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // bus writes
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   // cpu side and fuses
   input wire logic        sleep_instr,
   input wire logic        cpu_resume,
   input wire logic        sleeping,
   input wire logic [3:0]  clock_source_select_fuses,
   // wake sources
   input wire logic        irq_uart_txc,
   input wire logic        irq_power_stage_controller,
   // clock enables and analog
   input wire logic        clk_cpu_en,
   input wire logic        clk_flash_en,
   input wire logic        clk_io_en,
   input wire logic        clk_adc_en,
   input wire logic        clk_pll_en,
   input wire logic        osc_en,
   input wire logic        comparator_pd,
   input wire logic        adc_start
);
   // ------------------------------------------------------------
   // helper state
   // ------------------------------------------------------------
   logic [4:0] ctrl_q;
   logic [2:0] mode_q;
   wire        go   = sleep_instr && !sleeping;
   wire        xtal = clock_source_select_fuses[3];
   wire  [5:0] en   = {clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, clk_pll_en, osc_en};
   // control mirror follows bus writes; the mode is latched on every sleep request while awake, refused or not
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 5'h00;
         mode_q <= 3'h0;
      end else begin
         if (psel && penable && pwrite && paddr == 8'h00) ctrl_q <= pwdata[4:0];
         if (go) mode_q <= ctrl_q[2:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_take(logic [2:0] c);
      go && ctrl_q[2:0] == c;
   endsequence
   // standby wake must not come early; the bench pins the exact count
   sequence s_six_late;
      !cpu_resume [*6] ##[1:3] cpu_resume;
   endsequence
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   a_idle_gate : assert property (s_take(3'h0) |=> ##[0:1] en == 6'h0f)
      else $error("idle gating wrong");
   a_adcnr_gate : assert property (s_take(3'h1) |=> ##[0:1] en == 6'h07)
      else $error("adc noise gating wrong");
   a_pdown_gate : assert property (s_take(3'h2) |=> ##[0:1] en == 6'h00)
      else $error("power-down gating wrong");
   a_stby_gate : assert property (s_take(3'h6) and xtal |=> ##[0:1] en == 6'h01)
      else $error("standby gating wrong");
   a_rsv_nogate : assert property (go && !(ctrl_q[2:0] inside {3'h0, 3'h1, 3'h2})
      && !(ctrl_q[2:0] == 3'h6 && xtal) |=> (en == 6'h3f && !sleeping) [*3])
      else $error("reserved code gated a clock");
   a_adc_kick : assert property (go && ctrl_q[4] && ctrl_q[2:1] == 2'b00 |=> ##[0:1] adc_start)
      else $error("no conversion start on entry");
   a_comp_off : assert property (psel && penable && pwrite && paddr == 8'h00
      |=> comparator_pd == $past(pwdata[3]))
      else $error("comparator power-off not applied");
   a_idle_wake : assert property (sleeping && mode_q == 3'h0 && $rose(irq_uart_txc)
      |-> ##[1:3] (cpu_resume && clk_cpu_en))
      else $error("idle did not wake on interrupt");
   a_stby_wake : assert property (sleeping && mode_q == 3'h6
      && $rose(irq_power_stage_controller) |=> s_six_late)
      else $error("standby wake timing wrong");
   a_pdown_wait : assert property (sleeping && mode_q == 3'h2
      && $rose(irq_power_stage_controller) |-> ##[1:3] (osc_en && !clk_cpu_en && !cpu_resume))
      else $error("power-down wake skipped restart wait");
   a_resume_once : assert property (cpu_resume |=> !cpu_resume && !sleeping)
      else $error("resume pulse wrong");
endmodule : slpc_sleep_ctrl_props
bind slpc_sleep_ctrl slpc_sleep_ctrl_props i_slpc_sleep_ctrl_props (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .sleep_instr, .cpu_resume,
   .sleeping, .clock_source_select_fuses, .irq_uart_txc, .irq_power_stage_controller, .clk_cpu_en,
   .clk_flash_en, .clk_io_en, .clk_adc_en, .clk_pll_en, .osc_en, .comparator_pd, .adc_start
);
`default_nettype wire

/* File: verif/slpc_wake_src.sv */
// far-side model: peripheral interrupt sources and external level pins
`timescale 1ns/10ps
`default_nettype none
module slpc_wake_src (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // bench control
   input  wire logic [9:0] req,
   input  wire logic       drop,
   // device side
   input  wire logic       cpu_resume,
   output logic [8:0]      irq,
   output logic [3:0]      pins_n
);
   logic [9:0] held_q;
   // a source keeps its level until the cpu is back or the bench drops it, so a slow restart cannot lose it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) held_q <= 10'h000;
      else if (drop || cpu_resume) held_q <= 10'h000;
      else held_q <= held_q | req;
   end
   assign irq    = held_q[8:0];
   assign pins_n = {3'h7, ~held_q[9]}; // pins idle high, a low level requests
endmodule : slpc_wake_src
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the sleep controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb;
   import slpc_pkg::*;
   localparam int XT = 20; // shortened crystal restart count
   logic        pclk, presetn, psel, penable, pwrite, sleep_instr, drop, err, adc_seen;
   logic        pready, pslverr, cpu_resume, sleeping, comparator_pd, adc_start;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, lfsr_q;
   logic [3:0]  fuses, pins_n;
   logic [8:0]  irq;
   logic [9:0]  req;
   wire  [5:0]  en;
   int          err_total, tests_run, cyc, lat, lat_idle;
   int          bad_t[8]  = '{3, 1, 4, -1, -1, -1, 0, -1}; // refused source per code
   int          good_t[8] = '{1, 9, 6, -1, -1, -1, 6, -1}; // waking source per code
   slpc_sleep_ctrl #(.START_XT_CYC(XT)) i_slpc_sleep_ctrl (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .sleep_instr, .cpu_resume, .sleeping, .clock_source_select_fuses(fuses),
      .external_irq_pins(pins_n), .rst_external_n(1'b1), .rst_watchdog(1'b0), .rst_brownout(1'b0),
      .irq_timer(irq[0]), .irq_uart_txc(irq[1]), .irq_spi(irq[2]), .irq_comparator(irq[3]),
      .irq_adc_done(irq[4]), .irq_spm_ee_ready(irq[5]), .irq_power_stage_controller(irq[6]),
      .irq_other_io(irq[7]), .irq_ext_edge(irq[8]), .clk_cpu_en(en[5]), .clk_flash_en(en[4]),
      .clk_io_en(en[3]), .clk_adc_en(en[2]), .clk_pll_en(en[1]), .osc_en(en[0]), .comparator_pd,
      .adc_start
   );
   slpc_wake_src i_slpc_wake_src (.pclk, .presetn, .req, .drop, .cpu_resume, .irq, .pins_n);
   // ------------------------------------------------------------
   // clock, watchdog on the run, pulse catcher
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (adc_start === 1'b1) adc_seen <= 1'b1;
      if (cyc == 20000) begin
         err_total++;
         final_report();
      end
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   // one bus transfer, then an idle edge so the next request never doubles up on psel
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic pulse(input int idx);
      req <= 10'(1 << idx);
      @(posedge pclk);
      req <= 10'h000;
   endtask : pulse
   // request one mode; if it is taken, try a refused source, then wake and time the return
   task automatic run_mode(input int code, input int xt);
      logic [5:0] ee;
      logic       slp;
      slp = code inside {0, 1, 2} || (code == 6 && xt == 1);
      ee = !slp ? 6'h3f : code == 0 ? 6'h0f : code == 1 ? 6'h07 : code == 2 ? 6'h00 : 6'h01;
      apb(1'b1, 8'h00, 32'(16 + code + (code == 0 ? 8 : 0)));
      `CHK(comparator_pd, code == 0)
      adc_seen <= 1'b0;
      sleep_instr <= 1'b1;
      @(posedge pclk);
      sleep_instr <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK(en, ee)
      `CHK(adc_seen, slp && code < 2)
      apb(1'b0, 8'h08, 32'h0);
      `CHK({rd[5:4], rd[1:0]}, {1'(xt), !slp, 1'b0, slp})
      if (!slp) begin
         apb(1'b1, 8'h08, 32'h10);
         return;
      end
      `CHK(rd[3:2], code == 6 ? 2'h3 : 2'(code))
      if (bad_t[code] >= 0) begin
         pulse(bad_t[code]);
         repeat (12) @(posedge pclk);
         `CHK(sleeping, 1'b1)
         drop <= 1'b1;
         @(posedge pclk);
         drop <= 1'b0;
      end
      pulse(good_t[code]);
      lat = 1;
      while (cpu_resume !== 1'b1 && lat < 3000) begin
         @(posedge pclk);
         lat++;
      end
      `CHK(en, 6'h3f)
      if (code == 0) lat_idle = lat;
      if (code == 6) `CHK(lat - lat_idle, 6)
      if (code == 2) `CHK(lat - lat_idle, xt == 1 ? XT : 1600)
      repeat (2) @(posedge pclk);
   endtask : run_mode
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, sleep_instr, drop, adc_seen} = 7'h00;
      {paddr, pwdata, req} = '0;
      fuses = 4'h8; // crystal selected, so standby is a legal request
      lfsr_q = 32'habee4400;
      {err_total, tests_run, cyc, lat_idle} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK({en, sleeping}, 7'h7e)
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, 8'h0c, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      // random enable patterns through the wake register
      repeat (4) begin
         lfsr_q = lfsr(lfsr_q);
         apb(1'b1, 8'h04, lfsr_q);
         apb(1'b0, 8'h04, 32'h0);
         `CHK(rd, lfsr_q & 32'hff)
      end
      apb(1'b1, 8'h04, 32'h11); // pin 0 enabled in level mode
      for (int xt = 1; xt >= 0; xt--) begin
         fuses <= 4'(xt << 3);
         repeat (4) @(posedge pclk);
         for (int c = 0; c < 8; c++) run_mode(c, xt);
      end
      final_report();
   end
endmodule : tb
`default_nettype wire
